// >>> common/rrs_pkg.sv
// Shared types and constants for the return, rotate and sleep decode block.
// Assumes a 14-bit instruction word and 8-bit data path in the surrounding core.
package rrs_pkg;

  // ****************************************
  // Instruction encodings
  // ****************************************
  localparam logic [13:0] OPC_RETURN     = 14'h0008;  // Subroutine return.
  localparam logic [13:0] OPC_SLEEP      = 14'h0063;  // Enter sleep.
  localparam logic [5:0]  OPC_ROT_RIGHT  = 6'h0C;     // Upper six bits of right rotate.
  localparam logic [5:0]  OPC_ROT_LEFT   = 6'h0D;     // Upper six bits of left rotate.
  localparam int          OPC_HI_POS     = 8;         // Lowest bit of the opcode field.
  localparam int          DEST_POS       = 7;         // Destination select position.
  localparam int          ADDR_W         = 7;         // File address width.
  localparam int          DATA_W         = 8;         // Data path width.
  localparam int          PC_W           = 13;        // Program counter width.
  localparam logic [7:0]  WDT_CLEAR      = 8'h00;     // Watchdog clear value.
  localparam logic [1:0]  RETURN_CYCLES  = 2'h2;      // Return occupies two cycles.

  // ****************************************
  // Decoded operation
  // ****************************************
  typedef enum logic [4:0]
  {
    OP_NONE  = 5'h01,
    OP_RET   = 5'h02,
    OP_RRC   = 5'h04,
    OP_RLC   = 5'h08,
    OP_SLEEP = 5'h10
  } op_e;

  typedef struct packed
  {
    op_e                op;     // Which operation.
    logic               dest;   // Destination select.
    logic [ADDR_W-1:0]  addr;   // File register address.
  } decoded_s;

  // Result of the execute stage toward the core.
  typedef struct packed
  {
    logic               wEn;      // Write accumulator.
    logic               fileEn;   // Write file register.
    logic [ADDR_W-1:0]  fileAddr; // File register address.
    logic [DATA_W-1:0]  data;     // Rotated value.
    logic               carryEn;  // Update carry.
    logic               carry;    // New carry.
  } result_s;

endpackage

// >>> core/rrs_decoder.sv
// Pure combinational decoder of the four instruction words handled here.
// Assumes the instruction word is stable for the whole cycle it is presented.
`timescale 1ns/1ps
module rrs_decoder
(
  // Instruction in.
  input  wire logic [13:0]        instr,
  // Decoded result out.
  output rrs_pkg::decoded_s       decoded
);

  // ****************************************
  // Decode
  // ****************************************
  // The rotates carry address and destination in the low byte.
  always_comb
  begin
    decoded.dest = instr[rrs_pkg::DEST_POS];
    decoded.addr = instr[rrs_pkg::ADDR_W-1:0];
    if (instr == rrs_pkg::OPC_RETURN)
    begin
      decoded.op = rrs_pkg::OP_RET;
    end
    else if (instr == rrs_pkg::OPC_SLEEP)
    begin
      decoded.op = rrs_pkg::OP_SLEEP;
    end
    else if (instr[13:rrs_pkg::OPC_HI_POS] == rrs_pkg::OPC_ROT_RIGHT)
    begin
      decoded.op = rrs_pkg::OP_RRC;
    end
    else if (instr[13:rrs_pkg::OPC_HI_POS] == rrs_pkg::OPC_ROT_LEFT)
    begin
      decoded.op = rrs_pkg::OP_RLC;
    end
    else
    begin
      decoded.op = rrs_pkg::OP_NONE;
    end
  end

endmodule // rrs_decoder

// >>> core/return_rotate_sleep_decode.sv
// Execute logic for subroutine return, rotates through carry and sleep.
// Assumes the core presents one instruction per cycle when instrValid is high and
// holds it while busy is high; file read data is combinational for instr's address.
// Summary of operation
// - Return pops stack top into PC, two cycles.
// - Right rotate through carry, rotated data and carry both written.
// - Destination clear writes accumulator, file untouched.
// - Seven-bit address low, destination bit above.
// - Left rotate through carry, single cycle.
// - Destination set writes back file register.
// - Sleep halts oscillator; one word, one cycle.
// - Sleep clears watchdog counter and prescaler.
// - Sleep clears power-down flag, sets time-out flag.
`timescale 1ns/1ps
module return_rotate_sleep_decode
#(
  parameter int PC_W = rrs_pkg::PC_W  // Program counter width.
)
(
  // Clock and reset.
  input  wire logic                        sys_clk,
  input  wire logic                        reset,
  // Instruction stream.
  input  wire logic                        instrValid,
  input  wire logic [13:0]                 instr,
  output logic                             busy,
  // Operand sources.
  input  wire logic [rrs_pkg::DATA_W-1:0]  fileReadData,
  input  wire logic                        carryIn,
  input  wire logic [PC_W-1:0]             stack_top,
  // Results toward the core.
  output rrs_pkg::result_s                 result,
  output logic                             stackPop,
  output logic                             pcLoad,
  output logic [PC_W-1:0]                  pcValue,
  // Sleep and power status.
  output logic                             watchdogClear,
  output logic                             prescalerClear,
  output logic                             oscHalt,
  output logic                             powerdown_flag_n,
  output logic                             watchdog_expired_flag_n,
  input  wire logic                        wakeUp
);

  // ****************************************
  // State
  // ****************************************
  // All state lives in one struct; the outputs below come straight from it.
  typedef struct packed
  {
    logic [1:0]        retCount;  // Cycles of return left.
    rrs_pkg::result_s  res;       // Registered rotate result.
    logic              pop;       // Stack pop pulse.
    logic              load;      // PC load pulse.
    logic [PC_W-1:0]   pc;        // Value loaded into PC.
    logic              wdtClr;    // Watchdog clear pulse.
    logic              asleep;    // Oscillator halted.
    logic              pdN;       // Power-down flag, active low.
    logic              toN;       // Time-out flag, active low.
  } state_s;

  state_s             st;          // Current state.
  state_s             next_st;     // Next state.
  rrs_pkg::decoded_s  dec;         // Decoded instruction.
  logic               accept;      // A new instruction is taken.

  // ****************************************
  // Decoder
  // ****************************************
  rrs_decoder u_decoder
  (
    .instr   (instr),
    .decoded (dec)
  );

  // A return holds the pipe for its second cycle; sleep holds until wake-up.
  assign busy   = (st.retCount != 2'h0) || st.asleep;
  assign accept = instrValid && !busy;

  // Rotate one step; the vacated end gets the carry and the leaving bit becomes carry.
  function automatic logic [rrs_pkg::DATA_W:0] rotate
  (
    input logic                        right,
    input logic [rrs_pkg::DATA_W-1:0]  value,
    input logic                        cin
  );
    if (right)
    begin
      rotate = {value[0], cin, value[rrs_pkg::DATA_W-1:1]};
    end
    else
    begin
      rotate = {value[rrs_pkg::DATA_W-1], value[rrs_pkg::DATA_W-2:0], cin};
    end
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [rrs_pkg::DATA_W:0] rot;
    rot = rotate(dec.op == rrs_pkg::OP_RRC, fileReadData, carryIn);
    next_st = st;
    // Pulses drop after one cycle by default.
    next_st.res.wEn     = 1'b0;
    next_st.res.fileEn  = 1'b0;
    next_st.res.carryEn = 1'b0;
    next_st.pop         = 1'b0;
    next_st.load        = 1'b0;
    next_st.wdtClr      = 1'b0;
    if (st.retCount != 2'h0)
    begin
      // Second cycle of return is a dead cycle while the fetch refills.
      next_st.retCount = st.retCount - 2'h1;
    end
    if (st.asleep && wakeUp)
    begin
      next_st.asleep = 1'b0;
    end
    if (accept)
    begin
      case (dec.op)
        rrs_pkg::OP_RET:
        begin
          // Only the stack is read; no status or interrupt enable is touched.
          next_st.pop      = 1'b1;
          next_st.load     = 1'b1;
          next_st.pc       = stack_top;
          next_st.retCount = rrs_pkg::RETURN_CYCLES - 2'h1;
        end
        rrs_pkg::OP_RRC, rrs_pkg::OP_RLC:
        begin
          next_st.res.data     = rot[rrs_pkg::DATA_W-1:0];
          next_st.res.carry    = rot[rrs_pkg::DATA_W];
          next_st.res.carryEn  = 1'b1;
          next_st.res.fileAddr = dec.addr;
          next_st.res.wEn      = !dec.dest;
          next_st.res.fileEn   = dec.dest;
        end
        rrs_pkg::OP_SLEEP:
        begin
          next_st.wdtClr = 1'b1;
          next_st.asleep = 1'b1;
          next_st.pdN    = 1'b0;
          next_st.toN    = 1'b1;
        end
        default:
        begin
          next_st = next_st;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Flags reset to the power-on values: both status bits high.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st     <= '0;
      st.pdN <= 1'b1;
      st.toN <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output is a flop or a simple gate of flops, so the core never sees a decode glitch.
  assign result                  = st.res;
  assign stackPop                = st.pop;
  assign pcLoad                  = st.load;
  assign pcValue                 = st.pc;
  assign watchdogClear           = st.wdtClr;
  assign prescalerClear          = st.wdtClr;
  assign oscHalt                 = st.asleep;
  assign powerdown_flag_n        = st.pdN;
  assign watchdog_expired_flag_n = st.toN;

  // ****************************************
  // Checks
  // ****************************************
  // The properties on a taken word look one cycle later, which is when its effects stand; the others check outputs in the same cycle.
  // Data fields keep stale values between rotates; only the enables say whether they count.
  chk_ret_pc_load: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr == rrs_pkg::OPC_RETURN) |=> (pcLoad && stackPop && pcValue == $past(stack_top)))
    else $error("Return did not load PC from stack top.");
  chk_ret_two_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    pcLoad |-> busy)
    else $error("Return did not hold the second cycle.");
  chk_rrc_value: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr[13:8] == rrs_pkg::OPC_ROT_RIGHT) |=>
      (result.carryEn && result.carry == $past(fileReadData[0])
       && result.data == {$past(carryIn), $past(fileReadData[7:1])}))
    else $error("Right rotate value wrong.");
  chk_rlc_value: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr[13:8] == rrs_pkg::OPC_ROT_LEFT) |=>
      (result.carry == $past(fileReadData[7]) && result.data == {$past(fileReadData[6:0]), $past(carryIn)}))
    else $error("Left rotate value wrong.");
  chk_dest_acc: assert property (@(posedge sys_clk) disable iff (reset)
    result.wEn |-> !result.fileEn)
    else $error("Accumulator write also wrote file.");
  // A cleared destination bit must steer the rotate to the accumulator and nowhere else.
  chk_acc_write: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr[13:rrs_pkg::OPC_HI_POS+1] == 5'h06 && !instr[rrs_pkg::DEST_POS])
      |=> (result.wEn && !result.fileEn && result.fileAddr == $past(instr[rrs_pkg::ADDR_W-1:0])))
    else $error("Accumulator write-back missing.");
  chk_dest_file: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr[13:9] == 5'h06 && instr[7]) |=> (result.fileEn && result.fileAddr == $past(instr[6:0])))
    else $error("File write-back missing.");
  chk_sleep_flags: assert property (@(posedge sys_clk) disable iff (reset)
    (instrValid && !busy && instr == rrs_pkg::OPC_SLEEP) |=>
      (!powerdown_flag_n && watchdog_expired_flag_n && watchdogClear && prescalerClear && oscHalt))
    else $error("Sleep effects missing.");
  chk_ret_flags: assert property (@(posedge sys_clk) disable iff (reset)
    pcLoad |-> ($stable(powerdown_flag_n) && !result.carryEn))
    else $error("Return changed status.");

endmodule // return_rotate_sleep_decode

// >>> dv/testbench.sv
// Self-checking bench for the return, rotate and sleep decode block.
// Assumes the package and design files are compiled first; no far-side model is needed.
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Expected outcomes
  // ****************************************
  // One note per accepted instruction: kind 0 rotate, 1 return, 2 sleep.
  typedef struct packed
  {
    logic [1:0]        kind;
    rrs_pkg::result_s  res;
    logic [12:0]       pc;
  } note_s;
  note_s             notes[$];   // Outcomes not yet seen at the outputs.
  note_s             seen;       // Note taken by the watcher.
  int                errorCnt;   // Mismatches so far.
  int                numChecks;  // Comparisons so far.
  logic [31:0]       rnd;        // Random state.
  // ****************************************
  // Design connections
  // ****************************************
  logic              sys_clk;
  logic              reset;
  logic              instrValid;
  logic [13:0]       instr;
  logic              busy;
  logic [7:0]        fileReadData;
  logic              carryIn;
  logic [12:0]       stack_top;
  rrs_pkg::result_s  result;
  logic              stackPop;
  logic              pcLoad;
  logic [12:0]       pcValue;
  logic              watchdogClear;
  logic              prescalerClear;
  logic              oscHalt;
  logic              powerdown_flag_n;
  logic              watchdog_expired_flag_n;
  logic              wakeUp;
  return_rotate_sleep_decode i_return_rotate_sleep_decode
  (
    .sys_clk(sys_clk), .reset(reset), .instrValid(instrValid), .instr(instr), .busy(busy),
    .fileReadData(fileReadData), .carryIn(carryIn), .stack_top(stack_top), .result(result),
    .stackPop(stackPop), .pcLoad(pcLoad), .pcValue(pcValue), .watchdogClear(watchdogClear),
    .prescalerClear(prescalerClear), .oscHalt(oscHalt), .powerdown_flag_n(powerdown_flag_n),
    .watchdog_expired_flag_n(watchdog_expired_flag_n), .wakeUp(wakeUp)
  );
  // Free-running 125 MHz clock.
  always #4 sys_clk = ~sys_clk;
  // ****************************************
  // Helpers
  // ****************************************
  // Xorshift step; cheap and repeatable from a fixed seed.
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // Counts one comparison and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    numChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Prints the verdict and stops; also reached when a bounded wait runs out.
  task automatic endSim();
    if (errorCnt == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Presents one word at the current edge; it is taken at the next edge unless busy.
  task automatic drive(input logic [13:0] i, input logic [7:0] v, input logic c);
    instrValid   <= 1'h1;
    instr        <= i;
    fileReadData <= v;
    carryIn      <= c;
    @(posedge sys_clk);
  endtask
  // Drops the valid line for one cycle.
  task automatic idle();
    instrValid <= 1'h0;
    @(posedge sys_clk);
  endtask
  // Rotate through carry; a note is queued only when the word should be accepted.
  task automatic rot(input logic lft, input logic d, input logic [6:0] a, input logic [7:0] v,
                     input logic c, input logic taken);
    note_s n;
    n              = '0;
    n.res.wEn      = !d;
    n.res.fileEn   = d;
    n.res.fileAddr = a;
    n.res.carryEn  = 1'h1;
    n.res.data     = lft ? {v[6:0], c} : {c, v[7:1]};
    n.res.carry    = lft ? v[7] : v[0];
    if (taken)
      notes.push_back(n);
    drive({(lft ? rrs_pkg::OPC_ROT_LEFT : rrs_pkg::OPC_ROT_RIGHT), d, a}, v, c);
  endtask
  // Subroutine return with a given stack top.
  task automatic ret(input logic [12:0] s);
    note_s n;
    n         = '0;
    n.kind    = 2'h1;
    n.pc      = s;
    stack_top <= s;
    notes.push_back(n);
    drive(rrs_pkg::OPC_RETURN, 8'h00, 1'h0);
  endtask
  // ****************************************
  // Output watcher
  // ****************************************
  // Pulses are sampled mid-cycle, well clear of the launching edge.
  always @(negedge sys_clk)
    if (!reset && (result.wEn || result.fileEn || result.carryEn || stackPop || pcLoad || watchdogClear))
    begin
      if (notes.size() == 0)
        check("unexpected pulse", 32'h0, 32'h1);
      else
      begin
        seen = notes.pop_front();
        case (seen.kind)
          2'h0:
          begin
            check("result", 32'(seen.res), 32'(result));
            check("pcLoad", 32'h0, 32'(pcLoad));
          end
          2'h1:
          begin
            check("pop,load", 32'h3, 32'({stackPop, pcLoad}));
            check("pcValue", 32'(seen.pc), 32'(pcValue));
            check("busy", 32'h1, 32'(busy));
            check("flags", 32'h3, 32'({powerdown_flag_n, watchdog_expired_flag_n}));
            check("result enables", 32'h0, 32'({result.wEn, result.fileEn, result.carryEn}));
          end
          default:
          begin
            check("clears", 32'h3, 32'({watchdogClear, prescalerClear}));
            check("oscHalt", 32'h1, 32'(oscHalt));
            check("flags", 32'h1, 32'({powerdown_flag_n, watchdog_expired_flag_n}));
            check("result enables", 32'h0, 32'({result.wEn, result.fileEn, result.carryEn}));
          end
        endcase
      end
    end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'h0; reset = 1'h1; instrValid = 1'h0; instr = 14'h0000; fileReadData = 8'h00;
    carryIn = 1'h0; stack_top = 13'h0000; wakeUp = 1'h0; errorCnt = 0; numChecks = 0;
    rnd = 32'h280D5C1F;
    repeat (4) @(posedge sys_clk);
    reset <= 1'h0;
    // Back-to-back rotates with address boundaries first, then random operands.
    for (int i = 0; i < 40; i++)
    begin
      rnd = xs(rnd);
      rot(rnd[0], rnd[1], (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : rnd[8:2], rnd[16:9], rnd[17], 1'h1);
    end
    // A return blocks the word right behind it.
    rnd = xs(rnd);
    ret(rnd[12:0]);
    rot(1'h0, 1'h1, 7'h05, 8'hA5, 1'h1, 1'h0);
    idle();
    // Opcodes outside this block must leave every output quiet.
    drive(14'h0009, 8'h00, 1'h0);
    idle();
    // Sleep, then words offered while asleep are ignored until wake-up.
    notes.push_back('{kind: 2'h2, res: '0, pc: 13'h0000});
    drive(rrs_pkg::OPC_SLEEP, 8'h00, 1'h0);
    repeat (3) rot(1'h1, 1'h0, 7'h11, 8'h3C, 1'h0, 1'h0);
    idle();
    wakeUp <= 1'h1;
    @(posedge sys_clk);
    wakeUp <= 1'h0;
    @(negedge sys_clk);
    check("oscHalt", 32'h0, 32'(oscHalt));
    for (int w = 0; busy !== 1'h0; w++)
    begin
      if (w > 10)
      begin
        check("busy wait", 32'h0, 32'h1);
        endSim();
      end
      @(negedge sys_clk);
    end
    check("flags", 32'h1, 32'({powerdown_flag_n, watchdog_expired_flag_n}));
    @(posedge sys_clk);
    rot(1'h1, 1'h1, 7'h40, 8'h81, 1'h1, 1'h1);
    idle();
    // A second reset in mid-run restores both status flags.
    reset <= 1'h1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'h0;
    @(negedge sys_clk);
    check("flags", 32'h3, 32'({powerdown_flag_n, watchdog_expired_flag_n}));
    repeat (3) @(posedge sys_clk);
    check("notes left", 32'h0, 32'(notes.size()));
    endSim();
  end
endmodule // testbench
